//--- src/cgb_pkg.sv
package cgb_pkg;
    // register bus geometry
    localparam int unsigned ADDR_W       = 5;
    localparam int unsigned DATA_W       = 8;
    // offset dac geometry: eight msbs plus two lsbs
    localparam int unsigned DAC_W        = 10;
    localparam int unsigned DAC_LO_W     = 2;
    localparam int unsigned DAC_LO_POS   = 0;
    localparam int unsigned COLOR_N      = 5;
    localparam int unsigned COLOR_W      = 3;

    // page that holds the gain and offset dac bytes
    localparam logic [7:0] PAGE_GAIN_DAC = 8'h01;

    // register byte offsets inside a page
    localparam logic [4:0] OFS_GAIN_C4   = 5'h03;
    localparam logic [4:0] OFS_GAIN_C5   = 5'h04;
    localparam logic [4:0] OFS_DAC_HI_C1 = 5'h05;
    localparam logic [4:0] OFS_DAC_LO_C1 = 5'h06;
    localparam logic [4:0] OFS_DAC_HI_C2 = 5'h07;
    localparam logic [4:0] OFS_DAC_LO_C2 = 5'h08;
    localparam logic [4:0] OFS_DAC_HI_C3 = 5'h09;
    localparam logic [4:0] OFS_DAC_LO_C3 = 5'h0a;
    localparam logic [4:0] OFS_DAC_HI_C4 = 5'h0b;
    localparam logic [4:0] OFS_DAC_LO_C4 = 5'h0c;
    localparam logic [4:0] OFS_DAC_HI_C5 = 5'h0d;
    localparam logic [4:0] OFS_DAC_LO_C5 = 5'h0e;
    localparam logic [4:0] OFS_PAGE      = 5'h1f;

    // reset values
    localparam logic [7:0] RST_GAIN      = 8'h54;
    localparam logic [7:0] RST_DAC_HI    = 8'h80;
    localparam logic [1:0] RST_DAC_LO    = 2'h0;
    localparam logic [7:0] RST_PAGE      = 8'h00;

    // offset binary mid scale, zero offset
    localparam logic [9:0] DAC_MID       = 10'h200;

    // line color index codes
    localparam logic [2:0] COLOR_1       = 3'h1;
    localparam logic [2:0] COLOR_2       = 3'h2;
    localparam logic [2:0] COLOR_3       = 3'h3;
    localparam logic [2:0] COLOR_4       = 3'h4;
    localparam logic [2:0] COLOR_5       = 3'h5;
endpackage

//--- src/cgb_sel_if.sv
`timescale 1ns/1ns
// five sources, a color index and the picked word travel together
interface cgb_sel_if #(
    parameter int unsigned W = 8
);
    logic [W-1:0]                 src [cgb_pkg::COLOR_N];  // per-color words, color 1 first
    logic [cgb_pkg::COLOR_W-1:0]  color;                   // current line color, 1 to 5
    logic [W-1:0]                 sel;                     // word of the current color

    modport src_side (output src, output color, input sel);
    modport mux_side (input src, input color, output sel);
endinterface

//--- src/cgb_sel5.sv
`timescale 1ns/1ns
// five-to-one selector; width comes from the interface
module cgb_sel5 (
    cgb_sel_if.mux_side    bus
);
    // pick by line color; a code outside 1 to 5 falls back to color 1
    always_comb begin
        case (bus.color)
            cgb_pkg::COLOR_1: bus.sel = bus.src[0];
            cgb_pkg::COLOR_2: bus.sel = bus.src[1];
            cgb_pkg::COLOR_3: bus.sel = bus.src[2];
            cgb_pkg::COLOR_4: bus.sel = bus.src[3];
            cgb_pkg::COLOR_5: bus.sel = bus.src[4];
            default:          bus.sel = bus.src[0];
        endcase
    end
endmodule

//--- src/cgb_regs.sv
// Functional notes
// - five-color mode: gain picked per line color
// - color 4/5 gains idle outside five-color mode
// - five-color mode: dac msbs picked per line color
// - lsb register bits [1:0] complete dac
// - fixed mode: colors 1-3 drive red/green/blue
// - dac value is offset binary, 0x200 zero
// - color 4/5 dac idle outside five-color mode
// - page register at 0x1f selects page
`timescale 1ns/1ns
module cgb_regs (
    input  wire logic        clk_i,              // 100 MHz
    input  wire logic        reset_i,            // async, active high
    // register port
    input  wire logic [4:0]  reg_addr_i,         // offset within page
    input  wire logic [7:0]  reg_wdata_i,        // write byte
    input  wire logic        reg_wr_i,           // one-cycle write strobe
    input  wire logic        reg_rd_i,           // one-cycle read strobe
    output logic      [7:0]  reg_rdata_o,        // read byte, cycle after strobe only
    output logic      [7:0]  page_o,             // current page
    // line control from same-clock logic
    input  wire logic        five_color_line_mode_i, // high: five-color line mode
    input  wire logic [2:0]  line_color_i,       // color of current line, 1 to 5
    // colors 1-3 gain bytes live in a neighbour block
    input  wire logic [7:0]  gain_color1_i,
    input  wire logic [7:0]  gain_color2_i,
    input  wire logic [7:0]  gain_color3_i,
    // per-line selected settings
    output logic      [7:0]  line_gain_o,        // gain_selector output
    output logic      [9:0]  line_dac_o,         // offset_dac_selector output
    output logic      [9:0]  line_dac_ofs_o,     // same, two's complement offset
    // per-input settings
    output logic      [7:0]  red_sensor_input_gain_o,
    output logic      [7:0]  green_sensor_input_gain_o,
    output logic      [7:0]  blue_sensor_input_gain_o,
    output logic      [9:0]  red_sensor_input_dac_o,
    output logic      [9:0]  green_sensor_input_dac_o,
    output logic      [9:0]  blue_sensor_input_dac_o
);
    // register storage
    logic [7:0]  page_r;                         // page select
    logic [7:0]  gain_color4_r;                  // color 4 gain byte
    logic [7:0]  gain_color5_r;                  // color 5 gain byte
    logic [7:0]  dac_hi_r [cgb_pkg::COLOR_N];    // dac msbs, color 1 at index 0
    logic [1:0]  dac_lo_r [cgb_pkg::COLOR_N];    // dac lsbs, only two bits kept
    logic [7:0]  rdata_nxt;                      // read mux
    logic        page_hit;                       // access lands on this page
    logic [9:0]  dac_full [cgb_pkg::COLOR_N];    // joined 10-bit settings

    // selector carriers
    cgb_sel_if #(.W(8))  gain_bus ();
    cgb_sel_if #(.W(10)) dac_bus ();

    // only page 1 reaches the bank; the page register is decoded apart from this
    // so that software can always switch away again, whatever page is selected
    // a write on any other page is dropped here, never stored and applied later
    assign page_hit = (page_r == cgb_pkg::PAGE_GAIN_DAC);

    // page register answers on every page, so software can always leave
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            page_r <= cgb_pkg::RST_PAGE;
        end else if (reg_wr_i && reg_addr_i == cgb_pkg::OFS_PAGE) begin
            page_r <= reg_wdata_i;
        end
    end

    // gain bytes for colors 4 and 5
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            gain_color4_r <= cgb_pkg::RST_GAIN;
            gain_color5_r <= cgb_pkg::RST_GAIN;
        end else if (reg_wr_i && page_hit) begin
            // color 4 gain byte, no effect outside five-color mode
            if (reg_addr_i == cgb_pkg::OFS_GAIN_C4) begin
                gain_color4_r <= reg_wdata_i;
            end
            // color 5 gain byte, same limits as color 4
            if (reg_addr_i == cgb_pkg::OFS_GAIN_C5) begin
                gain_color5_r <= reg_wdata_i;
            end
        end
    end

    // dac msb and lsb bytes; msb at odd offsets from 5, lsb right after
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < cgb_pkg::COLOR_N; i++) begin
                // every color starts at mid-scale, zero offset
                dac_hi_r[i] <= cgb_pkg::RST_DAC_HI;
                dac_lo_r[i] <= cgb_pkg::RST_DAC_LO;
            end
        end else if (reg_wr_i && page_hit) begin
            for (int i = 0; i < cgb_pkg::COLOR_N; i++) begin
                if (reg_addr_i == 5'(cgb_pkg::OFS_DAC_HI_C1 + 5'(2 * i))) begin
                    dac_hi_r[i] <= reg_wdata_i;
                end
                // upper six bits are dropped: they are not stored at all
                if (reg_addr_i == 5'(cgb_pkg::OFS_DAC_LO_C1 + 5'(2 * i))) begin
                    dac_lo_r[i] <= reg_wdata_i[cgb_pkg::DAC_LO_POS +: cgb_pkg::DAC_LO_W];
                end
            end
        end
    end

    // read mux; other pages belong elsewhere and read as zero here
    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_addr_i == cgb_pkg::OFS_PAGE) begin
            rdata_nxt = page_r;
        end else if (page_hit) begin
            case (reg_addr_i)
                cgb_pkg::OFS_GAIN_C4:   rdata_nxt = gain_color4_r;
                cgb_pkg::OFS_GAIN_C5:   rdata_nxt = gain_color5_r;
                cgb_pkg::OFS_DAC_HI_C1: rdata_nxt = dac_hi_r[0];
                cgb_pkg::OFS_DAC_LO_C1: rdata_nxt = {6'h00, dac_lo_r[0]};
                cgb_pkg::OFS_DAC_HI_C2: rdata_nxt = dac_hi_r[1];
                cgb_pkg::OFS_DAC_LO_C2: rdata_nxt = {6'h00, dac_lo_r[1]};
                cgb_pkg::OFS_DAC_HI_C3: rdata_nxt = dac_hi_r[2];
                cgb_pkg::OFS_DAC_LO_C3: rdata_nxt = {6'h00, dac_lo_r[2]};
                cgb_pkg::OFS_DAC_HI_C4: rdata_nxt = dac_hi_r[3];
                cgb_pkg::OFS_DAC_LO_C4: rdata_nxt = {6'h00, dac_lo_r[3]};
                cgb_pkg::OFS_DAC_HI_C5: rdata_nxt = dac_hi_r[4];
                cgb_pkg::OFS_DAC_LO_C5: rdata_nxt = {6'h00, dac_lo_r[4]};
                default:                rdata_nxt = 8'h00;
            endcase
        end
    end

    // read data stands one cycle only, zero otherwise
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            // strobe sampled: byte stands for the next cycle only
            reg_rdata_o <= rdata_nxt;
        end else begin
            // zero between reads, so a stale byte is never taken for fresh data
            reg_rdata_o <= 8'h00;
        end
    end

    // join msb and lsb into one 10-bit setting per color
    always_comb begin
        for (int i = 0; i < cgb_pkg::COLOR_N; i++) begin
            dac_full[i] = {dac_hi_r[i], dac_lo_r[i]};
        end
    end

    // feed the selectors
    // colors 1 to 3 gains come from the neighbour block, 4 and 5 are stored here
    assign gain_bus.src[0] = gain_color1_i;
    assign gain_bus.src[1] = gain_color2_i;
    assign gain_bus.src[2] = gain_color3_i;
    assign gain_bus.src[3] = gain_color4_r;
    assign gain_bus.src[4] = gain_color5_r;
    // the sequencer steps the color once per line; held at 1 in fixed mode
    assign gain_bus.color  = five_color_line_mode_i ? line_color_i : cgb_pkg::COLOR_1;
    assign dac_bus.color   = five_color_line_mode_i ? line_color_i : cgb_pkg::COLOR_1;
    // all five dac words are stored here
    assign dac_bus.src[0]  = dac_full[0];
    assign dac_bus.src[1]  = dac_full[1];
    assign dac_bus.src[2]  = dac_full[2];
    assign dac_bus.src[3]  = dac_full[3];
    assign dac_bus.src[4]  = dac_full[4];

    cgb_sel5 u_gain_selector (
        .bus (gain_bus.mux_side)
    );

    cgb_sel5 u_offset_dac_selector (
        .bus (dac_bus.mux_side)
    );

    // selected line settings; in fixed mode they follow color 1
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            line_gain_o    <= cgb_pkg::RST_GAIN;
            line_dac_o     <= cgb_pkg::DAC_MID;
            // mid-scale dac and its zero offset
            line_dac_ofs_o <= 10'h000;
        end else begin
            // registered so the analog side sees one clean change per line
            line_gain_o    <= gain_bus.sel;
            line_dac_o     <= dac_bus.sel;
            // offset binary to two's complement: flip the top bit
            line_dac_ofs_o <= {~dac_bus.sel[9], dac_bus.sel[8:0]};
        end
    end

    // per-input settings; in five-color mode one shared path carries the line value
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            // reset gains and mid-scale dacs on every input
            red_sensor_input_gain_o   <= cgb_pkg::RST_GAIN;
            green_sensor_input_gain_o <= cgb_pkg::RST_GAIN;
            blue_sensor_input_gain_o  <= cgb_pkg::RST_GAIN;
            red_sensor_input_dac_o    <= cgb_pkg::DAC_MID;
            green_sensor_input_dac_o  <= cgb_pkg::DAC_MID;
            blue_sensor_input_dac_o   <= cgb_pkg::DAC_MID;
        end else if (five_color_line_mode_i) begin
            // one shared path: all three inputs take the line value
            red_sensor_input_gain_o   <= gain_bus.sel;
            green_sensor_input_gain_o <= gain_bus.sel;
            blue_sensor_input_gain_o  <= gain_bus.sel;
            red_sensor_input_dac_o    <= dac_bus.sel;
            green_sensor_input_dac_o  <= dac_bus.sel;
            blue_sensor_input_dac_o   <= dac_bus.sel;
        end else begin
            // colors 4 and 5 never reach an input here
            red_sensor_input_gain_o   <= gain_color1_i;
            green_sensor_input_gain_o <= gain_color2_i;
            blue_sensor_input_gain_o  <= gain_color3_i;
            red_sensor_input_dac_o    <= dac_full[0];
            green_sensor_input_dac_o  <= dac_full[1];
            blue_sensor_input_dac_o   <= dac_full[2];
        end
    end

    assign page_o = page_r;

    // checks beside the logic; each one is clocked and cut off while reset is high
    // a write to the page register lands on any page; it is the only way out
    // of a page that hides this bank
    a_page_write_lands: assert property (@(posedge clk_i) disable iff (reset_i)
        reg_wr_i && reg_addr_i == cgb_pkg::OFS_PAGE |=> page_o == $past(reg_wdata_i))
        else $error("page write not taken");

    // reading the page register answers on every page as well
    a_page_read_back: assert property (@(posedge clk_i) disable iff (reset_i)
        reg_rd_i && reg_addr_i == cgb_pkg::OFS_PAGE |=> reg_rdata_o == $past(page_r))
        else $error("page register readback wrong");

    // a gain write while another page is selected must leave the byte alone
    a_off_page_ignored: assert property (@(posedge clk_i) disable iff (reset_i)
        reg_wr_i && !page_hit && reg_addr_i == cgb_pkg::OFS_GAIN_C4 |=> $stable(gain_color4_r))
        else $error("gain write taken on wrong page");

    // reads of this bank from another page come back as zero
    a_off_page_read: assert property (@(posedge clk_i) disable iff (reset_i)
        reg_rd_i && !page_hit && reg_addr_i != cgb_pkg::OFS_PAGE |=> reg_rdata_o == 8'h00)
        else $error("bank visible on wrong page");

    // offsets past the last lsb byte hold nothing and read as zero;
    // a stray decode here would alias one of the dac bytes
    a_unmapped_read: assert property (@(posedge clk_i) disable iff (reset_i)
        reg_rd_i && page_hit && reg_addr_i > cgb_pkg::OFS_DAC_LO_C5 && reg_addr_i != cgb_pkg::OFS_PAGE
        |=> reg_rdata_o == 8'h00)
        else $error("unmapped offset read not zero");

    // five-color mode, color 4 line: the color 4 gain byte is picked
    a_gain_pick_c4: assert property (@(posedge clk_i) disable iff (reset_i)
        five_color_line_mode_i && line_color_i == cgb_pkg::COLOR_4 |=> line_gain_o == $past(gain_color4_r))
        else $error("color 4 gain not selected");

    // five-color mode, color 5 line: the color 5 gain byte is picked
    a_gain_pick_c5: assert property (@(posedge clk_i) disable iff (reset_i)
        five_color_line_mode_i && line_color_i == cgb_pkg::COLOR_5 |=> line_gain_o == $past(gain_color5_r))
        else $error("color 5 gain not selected");

    // a code outside 1 to 5 must not pick a stray byte; it behaves as color 1,
    // so a sequencer glitch gives a known gain rather than a random one
    a_bad_color_c1: assert property (@(posedge clk_i) disable iff (reset_i)
        five_color_line_mode_i && line_color_i > cgb_pkg::COLOR_5 |=> line_gain_o == $past(gain_color1_i))
        else $error("invalid color did not fall back to color 1");

    // fixed mode: line gain follows color 1, blue input gain takes color 3; the release
    // edge is skipped, the outputs still show their reset values after it
    a_gain_fixed_map: assert property (@(posedge clk_i) disable iff (reset_i)
        !reset_i && !five_color_line_mode_i |=> line_gain_o == $past(gain_color1_i)
                                                && blue_sensor_input_gain_o == $past(gain_color3_i))
        else $error("fixed mode gain mapping wrong");

    // fixed mode: color 4 or 5 gain writes cannot move the line gain while color 1 holds
    a_gain_c45_idle: assert property (@(posedge clk_i) disable iff (reset_i)
        (!reset_i && !five_color_line_mode_i) ##1 (!five_color_line_mode_i && $stable(gain_color1_i))
        |=> $stable(line_gain_o))
        else $error("color 4 or 5 gain leaked in fixed mode");

    // five-color mode, color 5 line: the color 5 dac word is picked
    a_dac_pick_c5: assert property (@(posedge clk_i) disable iff (reset_i)
        five_color_line_mode_i && line_color_i == cgb_pkg::COLOR_5
        |=> line_dac_o == {$past(dac_hi_r[4]), $past(dac_lo_r[4])})
        else $error("color 5 dac not selected");

    // five-color mode: the shared path puts the line dac word on every input,
    // here the red input during a color 2 line
    a_shared_dac_c2: assert property (@(posedge clk_i) disable iff (reset_i)
        five_color_line_mode_i && line_color_i == cgb_pkg::COLOR_2
        |=> red_sensor_input_dac_o == {$past(dac_hi_r[1]), $past(dac_lo_r[1])})
        else $error("color 2 dac not on the inputs");

    // lsb registers keep bits [1:0] only; bits [7:2] read back as zero
    a_lsb_read_upper: assert property (@(posedge clk_i) disable iff (reset_i)
        reg_rd_i && page_hit && reg_addr_i == cgb_pkg::OFS_DAC_LO_C2
        |=> reg_rdata_o == {6'h00, $past(dac_lo_r[1])})
        else $error("lsb register readback wrong");

    // an lsb write keeps exactly the two low data bits; the upper six
    // are thrown away, never shifted into the stored pair
    a_lsb_write_kept: assert property (@(posedge clk_i) disable iff (reset_i)
        reg_wr_i && page_hit && reg_addr_i == cgb_pkg::OFS_DAC_LO_C4
        |=> dac_lo_r[3] == $past(reg_wdata_i[1:0]))
        else $error("lsb write not kept");

    // fixed mode: color 2 dac word drives the green input
    a_fixed_dac_map: assert property (@(posedge clk_i) disable iff (reset_i)
        !five_color_line_mode_i |=> green_sensor_input_dac_o == {$past(dac_hi_r[1]), $past(dac_lo_r[1])})
        else $error("fixed mode green dac wrong");

    // fixed mode: color 1 dac word drives the red input
    a_fixed_red_dac: assert property (@(posedge clk_i) disable iff (reset_i)
        !five_color_line_mode_i |=> red_sensor_input_dac_o == {$past(dac_hi_r[0]), $past(dac_lo_r[0])})
        else $error("fixed mode red dac wrong");

    // fixed mode: with color 1 dac still, writes to colors 4 and 5 must not
    // show on the line dac
    a_dac_c45_idle: assert property (@(posedge clk_i) disable iff (reset_i)
        !five_color_line_mode_i ##1 !five_color_line_mode_i && $stable(dac_full[0])
        |=> $stable(line_dac_o))
        else $error("color 4 or 5 dac leaked in fixed mode");

    // offset binary: mid-scale means zero offset
    a_offset_binary: assert property (@(posedge clk_i) disable iff (reset_i)
        line_dac_o == cgb_pkg::DAC_MID |-> line_dac_ofs_o == 10'h000)
        else $error("mid scale is not zero offset");

    // read data stands one cycle only; a held byte could be taken for a second read
    // by a master that reads back to back
    a_read_one_cycle: assert property (@(posedge clk_i) disable iff (reset_i)
        !reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data held past its cycle");

    // cover points for the main scenarios
    c_five_color_run: cover property (@(posedge clk_i) disable iff (reset_i)
        five_color_line_mode_i && line_color_i == cgb_pkg::COLOR_1 ##[1:40]
        five_color_line_mode_i && line_color_i == cgb_pkg::COLOR_5);
    c_page_then_read: cover property (@(posedge clk_i) disable iff (reset_i)
        (reg_wr_i && reg_addr_i == cgb_pkg::OFS_PAGE) ##2 (reg_rd_i && page_hit));
    c_lsb_readback: cover property (@(posedge clk_i) disable iff (reset_i)
        reg_rd_i && page_hit && reg_addr_i == cgb_pkg::OFS_DAC_LO_C5);
    c_fixed_to_five: cover property (@(posedge clk_i) disable iff (reset_i)
        !five_color_line_mode_i ##1 five_color_line_mode_i);
    c_lsb_all_ones: cover property (@(posedge clk_i) disable iff (reset_i)
        reg_wr_i && page_hit && reg_addr_i == cgb_pkg::OFS_DAC_LO_C4 && reg_wdata_i == 8'hff);
endmodule

//--- bench/cgb_regs_tb_top.sv
`timescale 1ns/1ns
// self-checking bench for the page-1 gain and black-level offset bank
module cgb_regs_tb_top;
    logic        clk_i;          // 100 MHz
    logic        reset_i;        // async, active high
    logic [4:0]  addr;           // register offset
    logic [7:0]  wdata;          // write byte
    logic        wr;             // write strobe
    logic        rd;             // read strobe
    logic [7:0]  rdata;          // read byte
    logic [7:0]  page;           // page seen at the port
    logic        mode;           // high: five-color line mode
    logic [2:0]  color;          // line color index
    logic [7:0]  g1, g2, g3;     // colors 1-3 gains from the neighbour block
    logic [7:0]  lgain, rgain, ggain, bgain;
    logic [9:0]  ldac, lofs, rdac, gdac, bdac;
    logic [7:0]  m [16];         // bench copy of the page-1 bytes
    logic [7:0]  mpage;          // bench copy of the page register
    logic [7:0]  seen;           // last read byte
    integer      seed;           // fixed seed keeps runs repeatable
    int          bad_count;
    int          n_tests;

    cgb_regs u_cgb_regs (
        .clk_i                    (clk_i),
        .reset_i                  (reset_i),
        .reg_addr_i               (addr),
        .reg_wdata_i              (wdata),
        .reg_wr_i                 (wr),
        .reg_rd_i                 (rd),
        .reg_rdata_o              (rdata),
        .page_o                   (page),
        .five_color_line_mode_i   (mode),
        .line_color_i             (color),
        .gain_color1_i            (g1),
        .gain_color2_i            (g2),
        .gain_color3_i            (g3),
        .line_gain_o              (lgain),
        .line_dac_o               (ldac),
        .line_dac_ofs_o           (lofs),
        .red_sensor_input_gain_o  (rgain),
        .green_sensor_input_gain_o(ggain),
        .blue_sensor_input_gain_o (bgain),
        .red_sensor_input_dac_o   (rdac),
        .green_sensor_input_dac_o (gdac),
        .blue_sensor_input_dac_o  (bdac)
    );

    // free-running clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // single compare point; four-state equality so an unknown matches only an unknown
    task automatic check(input string name, input logic [9:0] got, input logic [9:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one-cycle write; the bench copy follows what the bank should keep
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_i);
        wr    <= 1'b0;
        if (a == 5'h1f) begin
            mpage = d;
        end else if (mpage == 8'h01 && a >= 5'h03 && a <= 5'h0e) begin
            // lsb bytes sit at even offsets and keep only two bits
            m[a] = (a >= 5'h06 && a[0] == 1'b0) ? {6'h00, d[1:0]} : d;
        end
    endtask

    // one-cycle read; data is looked at in the following cycle only
    task automatic rd_reg(input logic [4:0] a);
        @(posedge clk_i);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd   <= 1'b0;
        #1 seen = rdata;
    endtask

    // what a read of an offset should return
    function automatic logic [7:0] exp_rd(input logic [4:0] a);
        if (a == 5'h1f) return mpage;
        if (mpage == 8'h01 && a >= 5'h03 && a <= 5'h0e) return m[a];
        return 8'h00;
    endfunction

    // gain byte for a color; unknown codes fall back to color 1
    function automatic logic [7:0] gain_of(input logic [2:0] c);
        case (c)
            3'h2:    return g2;
            3'h3:    return g3;
            3'h4:    return m[3];
            3'h5:    return m[4];
            default: return g1;
        endcase
    endfunction

    // ten-bit dac word: msb byte then the two lsbs
    function automatic logic [9:0] dac_of(input logic [2:0] c);
        int k;
        k = (c >= 3'h1 && c <= 3'h5) ? int'(c) : 1;
        return {m[3 + 2 * k], m[4 + 2 * k][1:0]};
    endfunction

    // drive mode and color, let two edges pass, then compare every setting output
    task automatic chk_lines(input logic md, input logic [2:0] c);
        logic [2:0] lc;
        @(posedge clk_i);
        mode  <= md;
        color <= c;
        g1    <= 8'($random(seed));
        g2    <= 8'($random(seed));
        g3    <= 8'($random(seed));
        @(posedge clk_i);
        @(posedge clk_i);
        #1 lc = md ? c : 3'h1;
        check("line_gain", {2'b00, lgain}, {2'b00, gain_of(lc)});
        check("line_dac", ldac, dac_of(lc));
        check("line_dac_ofs", lofs, dac_of(lc) ^ cgb_pkg::DAC_MID);
        check("red_gain", {2'b00, rgain}, {2'b00, gain_of(md ? c : 3'h1)});
        check("green_gain", {2'b00, ggain}, {2'b00, gain_of(md ? c : 3'h2)});
        check("blue_gain", {2'b00, bgain}, {2'b00, gain_of(md ? c : 3'h3)});
        check("red_dac", rdac, dac_of(md ? c : 3'h1));
        check("green_dac", gdac, dac_of(md ? c : 3'h2));
        check("blue_dac", bdac, dac_of(md ? c : 3'h3));
    endtask

    // watchdog: a hang counts as a mismatch and still reaches the verdict
    initial begin
        #200000;
        bad_count++;
        $display("Error watchdog expected finish seen hang");
        results();
    end

    // main sequence
    initial begin
        seed = 32'hd1332bed;
        bad_count = 0;
        n_tests = 0;
        reset_i = 1'b1;
        {addr, wdata, wr, rd, mode, color} = '0;
        g1 = 8'h11;
        g2 = 8'h22;
        g3 = 8'h33;
        mpage = 8'h00;
        for (int i = 0; i < 16; i++) begin
            m[i] = (i == 3 || i == 4) ? 8'h54 : ((i >= 5 && i[0]) ? 8'h80 : 8'h00);
        end
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        // reset values: mid-scale dac means zero offset
        chk_lines(1'b0, 3'h1);
        $display("test reset values done");
        // page 0 hides the bank: writes ignored, reads zero
        wr_reg(5'h0d, 8'h5a);
        wr_reg(5'h03, 8'ha5);
        rd_reg(5'h0d);
        check("page0_read", {2'b00, seen}, {2'b00, exp_rd(5'h0d)});
        wr_reg(5'h1f, 8'h01);
        #1 check("page_o", {2'b00, page}, 10'h001);
        for (int a = 3; a <= 14; a++) begin
            rd_reg(5'(a));
            check("reset_reg", {2'b00, seen}, {2'b00, exp_rd(5'(a))});
        end
        $display("test paging and register defaults done");
        // random fills, read-back, unmapped offset, then every mode and color
        for (int r = 0; r < 6; r++) begin
            for (int a = 3; a <= 14; a++) begin
                wr_reg(5'(a), 8'($random(seed)));
            end
            if (r == 0) begin
                wr_reg(5'h0c, 8'hff); // all lsb bits set; only [1:0] may stay
            end
            for (int a = 2; a <= 16; a++) begin
                rd_reg(5'(a));
                check("readback", {2'b00, seen}, {2'b00, exp_rd(5'(a))});
            end
            for (int c = 0; c < 8; c++) begin
                chk_lines(1'b1, 3'(c));
                chk_lines(1'b0, 3'(c));
            end
        end
        $display("test selectors and fixed mapping done");
        // leaving page 1 hides the bank again
        wr_reg(5'h1f, 8'h02);
        rd_reg(5'h03);
        check("page2_read", {2'b00, seen}, 10'h000);
        rd_reg(5'h1f);
        check("page_read", {2'b00, seen}, 10'h002);
        $display("test page switch done");
        results();
    end
endmodule
